// >>> iso_link_rx_model.sv
module iso_link_rx_model (
    input wire logic clk,
    output logic pkt_valid,
    output iso_rx_match_pkg::iso_pkt_t pkt_header
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------
    // Link receive path: one header per valid cycle
    // --------------------
    initial begin
        pkt_valid = 1'b0;
        pkt_header = '0;
    end
    // Header and valid driven on the next edge, held until the next send or idle
    task automatic send(input iso_rx_match_pkg::iso_pkt_t h);
        @(posedge clk);
        pkt_valid <= 1'b1;
        pkt_header <= h;
    endtask
    // Released header flips so a stale value never looks valid
    task automatic idle();
        @(posedge clk);
        pkt_valid <= 1'b0;
        pkt_header <= ~pkt_header;
    endtask
endmodule // iso_link_rx_model

// >>> iso_receive_context_match.sv
// Contract
// [R1] Four tag enables select tags 11,10,01,00
// [R2] Bits 27 and 7 read zero
// [R3] Fifteen-bit start cycle value in 26:12
// [R4] Start-on-cycle waits for timer match
// [R5] Sync compared when descriptor waits on sync
// [R6] Tag 01 gated needs sync top bits 00
// [R7] Other tags filtered by enables alone
// [R8] Gate lock forces gate bit, read-only
// [R9] Six-bit channel select in 5:0
// [R10] Vendor registers in upper 2K window
// [R11] Vendor registers at 800, 808, 840
// [R12] Vendor registers loaded from EEPROM
// [R13] Software leaves vendor registers alone while linked
// [R14] Eight contexts at 32-byte stride
// [R15] Start-on-cycle enable clears on activation
// [R16] Multi-channel uses masks, ignores channel field
// [R17] Accept only when all conditions hold
module iso_receive_context_match #(
    parameter int unsigned CONTEXTS = iso_rx_match_pkg::NUM_CONTEXTS
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_ACK,
    input wire logic EE_LOAD_VALID,
    input wire logic [1:0] EE_LOAD_SEL,
    input wire logic [31:0] EE_LOAD_DATA,
    input wire logic TAG_ONE_GATE_LOCK,
    input wire logic [31:0] CYCLE_TIMER,
    input wire logic [CONTEXTS-1:0] CTX_RUN,
    input wire logic [CONTEXTS-1:0] START_ON_CYCLE_ARM,
    input wire logic [CONTEXTS-1:0] MULTI_CHANNEL_RECEIVE,
    input wire logic [CONTEXTS-1:0] WAIT_ON_SYNC,
    input wire logic [63:0] CHANNEL_MASK,
    input wire logic PKT_VALID,
    input wire iso_rx_match_pkg::iso_pkt_t PKT_HEADER,
    output logic [CONTEXTS-1:0] PKT_ACCEPT,
    output logic [CONTEXTS-1:0] CTX_ACTIVE,
    output logic [CONTEXTS-1:0] START_ON_CYCLE_ENABLE,
    output logic [31:0] ISO_DMA_PCI_CONTROL,
    output logic [31:0] ASYNC_DMA_PCI_CONTROL,
    output logic [31:0] LINK_CORE_OPTIONS
);

    // --------------------
    // Helper functions
    // --------------------

    // Pack stored fields into the 32-bit read image
    function automatic logic [31:0] filter_image(input iso_rx_match_pkg::filter_t f);
        logic [31:0] img;
        img = iso_rx_match_pkg::READ_ZERO;
        img[iso_rx_match_pkg::ACCEPT_TAG_THREE_POS -: 4] = f.accept_tag; // [R1]
        img[iso_rx_match_pkg::RSVD_HIGH_POS] = 1'b0; // [R2]
        img[iso_rx_match_pkg::START_CYCLE_HI_POS:iso_rx_match_pkg::START_CYCLE_LO_POS] =
            f.start_cycle_value; // [R3]
        img[iso_rx_match_pkg::SYNC_HI_POS:iso_rx_match_pkg::SYNC_LO_POS] = f.sync_value;
        img[iso_rx_match_pkg::RSVD_LOW_POS] = 1'b0; // [R2]
        img[iso_rx_match_pkg::TAG_ONE_GATE_POS] = f.tag_one_sync_gate;
        img[iso_rx_match_pkg::CHANNEL_HI_POS:0] = f.rx_channel_select; // [R9]
        return img;
    endfunction

    // Decode a context filter address; hit flag in the top bit
    function automatic logic [3:0] filter_decode(input logic [15:0] addr);
        logic [15:0] rel;
        logic [3:0] res;
        rel = addr - iso_rx_match_pkg::ISO_RX_CONTEXT_FILTER_OFS;
        res = 4'h0;
        // Stride of 32 bytes: low five bits zero, index in 7:5
        if ((addr >= iso_rx_match_pkg::ISO_RX_CONTEXT_FILTER_OFS) && (rel[4:0] == 5'h00) &&
            (rel[15:8] == 8'h00) && (32'(rel[7:5]) < CONTEXTS)) begin // [R14]
            res = {1'b1, rel[7:5]};
        end
        return res;
    endfunction

    // Vendor decode: inside the 4K window and in its upper half
    function automatic logic vendor_hit(input logic [15:0] addr, input logic [15:0] ofs);
        return ((addr & iso_rx_match_pkg::WINDOW_TOP_MASK) == 16'h0000) &&
               ((addr & iso_rx_match_pkg::VENDOR_HALF_BIT) != 16'h0000) && (addr == ofs); // [R10]
    endfunction

    // --------------------
    // Storage
    // --------------------
    iso_rx_match_pkg::filter_t filter_r [CONTEXTS]; // Per-context filter fields
    iso_rx_match_pkg::ctx_state_t state_r [CONTEXTS]; // Reception state
    logic [CONTEXTS-1:0] sotc_en_r; // Start-on-cycle enable
    logic [CONTEXTS-1:0] active_r; // Mirrors running state
    logic [CONTEXTS-1:0] accept_r; // Per-packet acceptance strobe
    logic [CONTEXTS-1:0] accept_nxt; // Acceptance before the strobe register
    logic [31:0] iso_ctl_r;
    logic [31:0] async_ctl_r;
    logic [31:0] link_opt_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic ack_r;
    logic [3:0] filt_sel; // Decoded context of the current access
    logic [14:0] timer_now; // Seconds low bits and cycle index
    logic [CONTEXTS-1:0] cycle_hit; // Timer equals start cycle value

    assign filt_sel = filter_decode(REG_ADDR);
    assign timer_now = CYCLE_TIMER[iso_rx_match_pkg::TIMER_MATCH_HI_POS:iso_rx_match_pkg::TIMER_MATCH_LO_POS];

    // --------------------
    // Filter registers
    // --------------------

    // Software writes; lock keeps the gate bit at one
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < CONTEXTS; i++) begin
            if (RESET) begin
                filter_r[i] <= iso_rx_match_pkg::FILTER_RST;
            end else begin
                if (REG_WR && filt_sel[3] && (32'(filt_sel[2:0]) == i)) begin
                    filter_r[i].accept_tag <= REG_WDATA[iso_rx_match_pkg::ACCEPT_TAG_THREE_POS -: 4]; // [R1]
                    filter_r[i].start_cycle_value <=
                        REG_WDATA[iso_rx_match_pkg::START_CYCLE_HI_POS:iso_rx_match_pkg::START_CYCLE_LO_POS]; // [R3]
                    filter_r[i].sync_value <= REG_WDATA[iso_rx_match_pkg::SYNC_HI_POS:iso_rx_match_pkg::SYNC_LO_POS];
                    filter_r[i].rx_channel_select <= REG_WDATA[iso_rx_match_pkg::CHANNEL_HI_POS:0]; // [R9]
                    filter_r[i].tag_one_sync_gate <= REG_WDATA[iso_rx_match_pkg::TAG_ONE_GATE_POS];
                end
                // Lock overrides any write to the gate bit
                if (TAG_ONE_GATE_LOCK) begin
                    filter_r[i].tag_one_sync_gate <= 1'b1; // [R8]
                end
            end
        end
    end

    // --------------------
    // Vendor registers
    // --------------------

    // Loader wins a clash; keeping writes off a live link is software's job
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            iso_ctl_r <= iso_rx_match_pkg::ISO_DMA_PCI_CONTROL_RST;
            async_ctl_r <= iso_rx_match_pkg::ASYNC_DMA_PCI_CONTROL_RST;
            link_opt_r <= iso_rx_match_pkg::LINK_CORE_OPTIONS_RST;
        end else if (EE_LOAD_VALID) begin
            case (EE_LOAD_SEL) // [R12]
                iso_rx_match_pkg::EE_SEL_ISO: begin
                    iso_ctl_r <= EE_LOAD_DATA;
                end
                iso_rx_match_pkg::EE_SEL_ASYNC: begin
                    async_ctl_r <= EE_LOAD_DATA;
                end
                iso_rx_match_pkg::EE_SEL_LINK: begin
                    link_opt_r <= EE_LOAD_DATA;
                end
                default: begin
                    // Unused selector, nothing loaded
                end
            endcase
        end else if (REG_WR) begin
            // Exact offsets within the upper half
            if (vendor_hit(REG_ADDR, iso_rx_match_pkg::ISO_DMA_PCI_CONTROL_OFS)) begin // [R11]
                iso_ctl_r <= REG_WDATA;
            end
            if (vendor_hit(REG_ADDR, iso_rx_match_pkg::ASYNC_DMA_PCI_CONTROL_OFS)) begin // [R11]
                async_ctl_r <= REG_WDATA;
            end
            if (vendor_hit(REG_ADDR, iso_rx_match_pkg::LINK_CORE_OPTIONS_OFS)) begin // [R11]
                link_opt_r <= REG_WDATA;
            end
        end
    end

    // --------------------
    // Read path
    // --------------------

    // Read mux; unmapped addresses return zero
    always_comb begin
        rdata_nxt = iso_rx_match_pkg::READ_ZERO;
        if (filt_sel[3]) begin
            rdata_nxt = filter_image(filter_r[filt_sel[2:0]]); // [R2]
        end else if (vendor_hit(REG_ADDR, iso_rx_match_pkg::ISO_DMA_PCI_CONTROL_OFS)) begin
            rdata_nxt = iso_ctl_r;
        end else if (vendor_hit(REG_ADDR, iso_rx_match_pkg::ASYNC_DMA_PCI_CONTROL_OFS)) begin
            rdata_nxt = async_ctl_r;
        end else if (vendor_hit(REG_ADDR, iso_rx_match_pkg::LINK_CORE_OPTIONS_OFS)) begin
            rdata_nxt = link_opt_r;
        end
    end

    // Registered answer one cycle after each access
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_r <= iso_rx_match_pkg::READ_ZERO;
            ack_r <= 1'b0;
        end else begin
            ack_r <= REG_WR | REG_RD;
            // Data holds its last value between reads
            if (REG_RD) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // --------------------
    // Start-on-cycle and context state
    // --------------------

    // Compare the timer slice with each start cycle value
    always_comb begin
        for (int i = 0; i < CONTEXTS; i++) begin
            cycle_hit[i] = (timer_now == filter_r[i].start_cycle_value); // [R4]
        end
    end

    // Enable bit: arm sets it, activation clears it; arm wins a clash
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < CONTEXTS; i++) begin
            if (RESET) begin
                sotc_en_r[i] <= 1'b0;
            end else if (START_ON_CYCLE_ARM[i]) begin
                sotc_en_r[i] <= 1'b1;
            end else if (state_r[i] == iso_rx_match_pkg::CTX_WAIT_CYCLE && CTX_RUN[i] && cycle_hit[i]) begin
                sotc_en_r[i] <= 1'b0; // [R15]
            end
        end
    end

    // Context state machine; dropping run always returns to idle
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < CONTEXTS; i++) begin
            if (RESET) begin
                state_r[i] <= iso_rx_match_pkg::CTX_IDLE;
                active_r[i] <= 1'b0;
            end else if (!CTX_RUN[i]) begin
                state_r[i] <= iso_rx_match_pkg::CTX_IDLE;
                active_r[i] <= 1'b0;
            end else begin
                case (state_r[i])
                    iso_rx_match_pkg::CTX_IDLE: begin
                        // Hold for the timer when start-on-cycle is enabled
                        if (sotc_en_r[i]) begin
                            state_r[i] <= iso_rx_match_pkg::CTX_WAIT_CYCLE; // [R4]
                        end else begin
                            state_r[i] <= iso_rx_match_pkg::CTX_RUNNING;
                            active_r[i] <= 1'b1;
                        end
                    end
                    iso_rx_match_pkg::CTX_WAIT_CYCLE: begin
                        if (cycle_hit[i]) begin
                            state_r[i] <= iso_rx_match_pkg::CTX_RUNNING; // [R4]
                            active_r[i] <= 1'b1;
                        end
                    end
                    iso_rx_match_pkg::CTX_RUNNING: begin
                        active_r[i] <= 1'b1;
                    end
                    default: begin
                        state_r[i] <= iso_rx_match_pkg::CTX_IDLE;
                        active_r[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // --------------------
    // Packet acceptance
    // --------------------

    // All conditions at once; several contexts may take one packet,
    // arbitration is left to the DMA side
    always_comb begin
        for (int i = 0; i < CONTEXTS; i++) begin
            accept_nxt[i] = PKT_VALID && active_r[i] &&
                // Enable bit indexed by tag value
                filter_r[i].accept_tag[PKT_HEADER.tag] && // [R1] [R7]
                // Channel from the mask in multi-channel mode
                (MULTI_CHANNEL_RECEIVE[i] ? CHANNEL_MASK[PKT_HEADER.channel] : // [R16]
                 (PKT_HEADER.channel == filter_r[i].rx_channel_select)) && // [R9]
                // Gate applies to tag 01 only
                (!(filter_r[i].tag_one_sync_gate && (PKT_HEADER.tag == 2'h1)) || // [R6]
                 (PKT_HEADER.sync[3:2] == 2'h0)) &&
                // Sync compare only when the descriptor waits on sync
                (!WAIT_ON_SYNC[i] || (PKT_HEADER.sync == filter_r[i].sync_value)); // [R5]
        end
    end

    // One-cycle strobe per context for each accepted packet
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            accept_r <= '0;
        end else begin
            accept_r <= accept_nxt; // [R17]
        end
    end

    // --------------------
    // Outputs, all from flip-flops
    // --------------------
    assign REG_RDATA = rdata_r;
    assign REG_ACK = ack_r;
    assign PKT_ACCEPT = accept_r;
    assign CTX_ACTIVE = active_r;
    assign START_ON_CYCLE_ENABLE = sotc_en_r;
    assign ISO_DMA_PCI_CONTROL = iso_ctl_r;
    assign ASYNC_DMA_PCI_CONTROL = async_ctl_r;
    assign LINK_CORE_OPTIONS = link_opt_r;

endmodule // iso_receive_context_match

// >>> iso_rx_match_pkg.sv
package iso_rx_match_pkg;

    // --------------------
    // Register window layout
    // --------------------
    localparam logic [15:0] WINDOW_TOP_MASK = 16'hF000;       // Bits above the 4K window
    localparam logic [15:0] VENDOR_HALF_BIT = 16'h0800;       // Upper 2K of the 4K window
    localparam logic [15:0] ISO_DMA_PCI_CONTROL_OFS = 16'h0800;
    localparam logic [15:0] ASYNC_DMA_PCI_CONTROL_OFS = 16'h0808;
    localparam logic [15:0] LINK_CORE_OPTIONS_OFS = 16'h0840;
    localparam logic [15:0] ISO_RX_CONTEXT_FILTER_OFS = 16'h410C; // Context 0 filter
    localparam logic [15:0] CONTEXT_STRIDE = 16'h0020;        // 32 bytes per context
    localparam int unsigned NUM_CONTEXTS = 8;                 // Contexts 0 to 7

    // --------------------
    // Filter register field positions
    // --------------------
    localparam int unsigned ACCEPT_TAG_THREE_POS = 31;
    localparam int unsigned ACCEPT_TAG_ZERO_POS = 28;
    localparam int unsigned RSVD_HIGH_POS = 27;               // Reads zero
    localparam int unsigned START_CYCLE_HI_POS = 26;
    localparam int unsigned START_CYCLE_LO_POS = 12;
    localparam int unsigned SYNC_HI_POS = 11;
    localparam int unsigned SYNC_LO_POS = 8;
    localparam int unsigned RSVD_LOW_POS = 7;                 // Reads zero
    localparam int unsigned TAG_ONE_GATE_POS = 6;
    localparam int unsigned CHANNEL_HI_POS = 5;

    // --------------------
    // Cycle timer fields compared against the start cycle
    // --------------------
    localparam int unsigned TIMER_MATCH_HI_POS = 26;          // Low two seconds bits at 26:25
    localparam int unsigned TIMER_MATCH_LO_POS = 12;          // Cycle index at 24:12

    // --------------------
    // Reset values
    // --------------------
    localparam logic [31:0] ISO_DMA_PCI_CONTROL_RST = 32'h0000_7373;
    localparam logic [31:0] ASYNC_DMA_PCI_CONTROL_RST = 32'h0010_7373;
    localparam logic [31:0] LINK_CORE_OPTIONS_RST = 32'h0000_0000;
    localparam logic [29:0] FILTER_RST = 30'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // --------------------
    // Serial EEPROM load selectors
    // --------------------
    localparam logic [1:0] EE_SEL_ISO = 2'h0;
    localparam logic [1:0] EE_SEL_ASYNC = 2'h1;
    localparam logic [1:0] EE_SEL_LINK = 2'h2;

    // --------------------
    // Types
    // --------------------
    // Stored filter fields, reserved bits left out
    typedef struct packed {
        logic [3:0] accept_tag;          // Three, two, one, zero
        logic [14:0] start_cycle_value;  // Seconds low two bits, then cycle index
        logic [3:0] sync_value;
        logic tag_one_sync_gate;
        logic [5:0] rx_channel_select;
    } filter_t;

    // Header fields of one received isochronous packet
    typedef struct packed {
        logic [1:0] tag;
        logic [3:0] sync;
        logic [5:0] channel;
    } iso_pkt_t;

    // Per-context reception state
    typedef enum logic [1:0] {
        CTX_IDLE = 2'b00,
        CTX_WAIT_CYCLE = 2'b01,
        CTX_RUNNING = 2'b10
    } ctx_state_t;

endpackage

// >>> iso_rx_match_sva.sv
module iso_rx_match_sva #(
    parameter int unsigned CONTEXTS = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic EE_LOAD_VALID,
    input wire logic [1:0] EE_LOAD_SEL,
    input wire logic [31:0] EE_LOAD_DATA,
    input wire logic [CONTEXTS-1:0] CTX_RUN,
    input wire logic [CONTEXTS-1:0] START_ON_CYCLE_ARM,
    input wire logic [CONTEXTS-1:0] MULTI_CHANNEL_RECEIVE,
    input wire logic [63:0] CHANNEL_MASK,
    input wire logic PKT_VALID,
    input wire iso_rx_match_pkg::iso_pkt_t PKT_HEADER,
    input wire logic [CONTEXTS-1:0] PKT_ACCEPT,
    input wire logic [CONTEXTS-1:0] CTX_ACTIVE,
    input wire logic [CONTEXTS-1:0] START_ON_CYCLE_ENABLE,
    input wire logic [31:0] ISO_DMA_PCI_CONTROL
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------
    // One clock domain, reset masks every attempt
    // --------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    // Every access answered exactly one cycle later, never otherwise
    property p_ack; 1 |=> REG_ACK == $past(REG_WR || REG_RD); endproperty
    a_ack: assert property (p_ack) else $error("Acknowledge timing wrong");
    // Filter image never shows its two reserved bits
    property p_rsvd; REG_RD && REG_ADDR[15:8] == 8'h41 && REG_ADDR[4:0] == 5'h0C |=> !REG_RDATA[27] && !REG_RDATA[7]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("Reserved filter bit reads one");
    // Accept only follows a cycle that carried a header
    property p_pulse; !PKT_VALID |=> PKT_ACCEPT == '0; endproperty
    a_pulse: assert property (p_pulse) else $error("Accept without a packet");
    // An idle context takes nothing
    property p_gate; PKT_VALID |=> (PKT_ACCEPT & ~$past(CTX_ACTIVE)) == '0; endproperty
    a_gate: assert property (p_gate) else $error("Idle context accepted");
    // Mask decides the channel in multi-channel mode
    property p_multi; PKT_VALID |=> (PKT_ACCEPT & $past(MULTI_CHANNEL_RECEIVE) & ~{CONTEXTS{$past(CHANNEL_MASK[PKT_HEADER.channel])}}) == '0; endproperty
    a_multi: assert property (p_multi) else $error("Masked channel accepted");
    // Enable only drops as the context turns active
    property p_soc_clear; 1 |=> ($past(START_ON_CYCLE_ENABLE) & ~START_ON_CYCLE_ENABLE & ~CTX_ACTIVE) == '0; endproperty
    a_soc_clear: assert property (p_soc_clear) else $error("Start enable dropped while idle");
    // Arm pulse always sets the enable
    property p_arm; 1 |=> ($past(START_ON_CYCLE_ARM) & ~START_ON_CYCLE_ENABLE) == '0; endproperty
    a_arm: assert property (p_arm) else $error("Arm did not set start enable");
    // Run low sends the context idle next cycle
    property p_run_idle; 1 |=> (CTX_ACTIVE & ~$past(CTX_RUN)) == '0; endproperty
    a_run_idle: assert property (p_run_idle) else $error("Active without run");
    // Without start-on-cycle the context starts at once
    property p_start_now; 1 |=> ($past(CTX_RUN & ~START_ON_CYCLE_ENABLE) & ~CTX_ACTIVE) == '0; endproperty
    a_start_now: assert property (p_start_now) else $error("Context failed to start");
    // Loader word lands in the isochronous control register
    property p_ee; EE_LOAD_VALID && EE_LOAD_SEL == 2'h0 |=> ISO_DMA_PCI_CONTROL == $past(EE_LOAD_DATA); endproperty
    a_ee: assert property (p_ee) else $error("Loader word not taken");
endmodule // iso_rx_match_sva

bind iso_receive_context_match iso_rx_match_sva #(.CONTEXTS(CONTEXTS)) sva_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .EE_LOAD_VALID(EE_LOAD_VALID), .EE_LOAD_SEL(EE_LOAD_SEL), .EE_LOAD_DATA(EE_LOAD_DATA), .CTX_RUN(CTX_RUN),
    .START_ON_CYCLE_ARM(START_ON_CYCLE_ARM), .MULTI_CHANNEL_RECEIVE(MULTI_CHANNEL_RECEIVE),
    .CHANNEL_MASK(CHANNEL_MASK), .PKT_VALID(PKT_VALID), .PKT_HEADER(PKT_HEADER), .PKT_ACCEPT(PKT_ACCEPT),
    .CTX_ACTIVE(CTX_ACTIVE), .START_ON_CYCLE_ENABLE(START_ON_CYCLE_ENABLE),
    .ISO_DMA_PCI_CONTROL(ISO_DMA_PCI_CONTROL));

// >>> tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------
    // Stimulus, observation and bookkeeping
    // --------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ee_v = 1'b0, lock = 1'b0, pv, reg_ack;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0, ee_d = 32'h0, timer = 32'h0, reg_rdata, iso, asy, lnk;
    logic [1:0] ee_sel = 2'h0;
    logic [7:0] run = 8'h00, arm = 8'h00, multi = 8'h00, wsync = 8'h00, acc, act, soce;
    logic [63:0] mask = 64'h0;
    iso_rx_match_pkg::iso_pkt_t ph;
    logic [31:0] flt [8];  // Expected filter images
    logic [31:0] vx [3];   // Expected vendor registers
    int errors = 0;
    int n_compared = 0;

    always #50 clk = ~clk;  // 10 MHz

    iso_receive_context_match dut_u (.CORE_CLK(clk), .RESET(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
        .EE_LOAD_VALID(ee_v), .EE_LOAD_SEL(ee_sel), .EE_LOAD_DATA(ee_d), .TAG_ONE_GATE_LOCK(lock),
        .CYCLE_TIMER(timer), .CTX_RUN(run), .START_ON_CYCLE_ARM(arm), .MULTI_CHANNEL_RECEIVE(multi),
        .WAIT_ON_SYNC(wsync), .CHANNEL_MASK(mask), .PKT_VALID(pv), .PKT_HEADER(ph), .PKT_ACCEPT(acc),
        .CTX_ACTIVE(act), .START_ON_CYCLE_ENABLE(soce), .ISO_DMA_PCI_CONTROL(iso),
        .ASYNC_DMA_PCI_CONTROL(asy), .LINK_CORE_OPTIONS(lnk));
    iso_link_rx_model pkt_u (.clk(clk), .pkt_valid(pv), .pkt_header(ph));

    // --------------------
    // Shared tasks and expectation functions
    // --------------------
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // One strobe pulse, answer taken one edge later
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk(reg_ack, 1'b1);
    endtask
    // Read data holds until the next read
    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(reg_rdata, e);
    endtask
    // Reserved bits clear, gate forced while locked
    function automatic logic [31:0] img(input logic [31:0] w, input logic lk);
        img = w & 32'hF7FF_FF7F;
        if (lk) img[6] = 1'b1;
    endfunction
    // All conditions together decide acceptance per context
    function automatic logic [7:0] acc_exp(input iso_rx_match_pkg::iso_pkt_t p);
        logic ch;
        for (int i = 0; i < 8; i++) begin
            ch = multi[i] ? mask[p.channel] : (p.channel == flt[i][5:0]);
            acc_exp[i] = ch && flt[i][28 + p.tag] && (p.tag != 2'b01 || !flt[i][6] || p.sync[3:2] == 2'b00)
                && (!wsync[i] || p.sync == flt[i][11:8]);
        end
    endfunction
    task automatic stop_test();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected 554 cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        logic [31:0] d;
        logic [15:0] a;
        logic [14:0] st;
        logic [7:0] ex;
        iso_rx_match_pkg::iso_pkt_t p;
        void'($urandom(36107));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        vx = '{32'h0000_7373, 32'h0010_7373, 32'h0};
        // Vendor registers only touched while every context is stopped
        for (int k = 0; k < 3; k++) begin
            a = k == 0 ? 16'h0800 : k == 1 ? 16'h0808 : 16'h0840;
            rdc(a, vx[k]);
            d = $urandom;
            bus(1'b1, a, d);
            bus(1'b1, a & 16'h07FF, ~d);
            bus(1'b1, a | 16'h1000, ~d);
            vx[k] = d;
            rdc(a, d);
            rdc(a | 16'h1000, 32'h0);
        end
        // Loader words, unused selector, and a losing software write
        for (int s = 0; s < 4; s++) begin
            d = $urandom;
            @(posedge clk);
            ee_v <= 1'b1;
            ee_sel <= 2'(s);
            ee_d <= d;
            reg_wr <= (s == 0);
            reg_addr <= 16'h0800;
            reg_wdata <= ~d;
            @(posedge clk);
            ee_v <= 1'b0;
            reg_wr <= 1'b0;
            if (s < 3) vx[s] = d;
            #1;
            chk({iso, asy, lnk}, {vx[0], vx[1], vx[2]});
        end
        // Locked gate reads one although written zero
        @(posedge clk);
        lock <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            a = 16'h410C + 16'(32 * n);
            rdc(a, img(32'h0, 1'b1));
            d = $urandom & 32'hFFFF_FFBF;
            bus(1'b1, a, d);
            rdc(a, img(d, 1'b1));
        end
        // Random filter rounds with back-to-back packets
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            lock <= 1'b0;
            run <= 8'hFF;
            multi <= 8'(1 << $urandom_range(7));
            wsync <= 8'($urandom);
            mask <= {$urandom, $urandom};
            for (int n = 0; n < 8; n++) begin
                a = 16'h410C + 16'(32 * n);
                d = $urandom;
                flt[n] = img(d, 1'b0);
                bus(1'b1, a, d);
                rdc(a, flt[n]);
            end
            chk(act, 8'hFF);
            ex = 8'h00;
            repeat (40) begin
                a = 16'($urandom_range(7));
                p.tag = 2'($urandom);
                p.sync = $urandom_range(1) ? flt[a][11:8] : 4'($urandom);
                p.channel = $urandom_range(3) ? flt[a][5:0] : 6'($urandom);
                pkt_u.send(p);
                #1;
                chk(acc, ex);
                ex = acc_exp(p);
            end
            pkt_u.idle();
            #1;
            chk(acc, ex);
        end
        // Start-on-cycle on context 0
        @(posedge clk);
        run <= 8'h00;
        arm <= 8'h01;
        @(posedge clk);
        arm <= 8'h00;
        #1;
        chk({act, soce}, 16'h0001);
        st = 15'($urandom_range(32767, 1));
        d = $urandom;
        d[26:12] = st;
        bus(1'b1, 16'h410C, d);
        @(posedge clk);
        run <= 8'h01;
        repeat (5) @(posedge clk);
        #1;
        chk({act[0], soce[0]}, 2'b01);
        @(posedge clk);
        timer <= {5'($urandom), st, 12'($urandom)};
        repeat (2) @(posedge clk);
        #1;
        chk({act[0], soce[0]}, 2'b10);
        stop_test();
    end
endmodule // tb_top
